// File: fdm_misc_cmd.sv
// floppy misc command handler: dump, read id, perpendicular, lock, invalid,
// and the front end of data-transfer commands with the implied seek.
// assumes host bytes arrive one per cycle via cmdValid/cmdReady and results
// leave via resValid/resTake; seek and media logic live outside.
`timescale 1ns/1ps
`default_nettype none
`include "fdm_params.svh"
module fdm_misc_cmd
  import fdm_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  // host command bytes
  input  wire logic            cmdValid,
  input  wire logic [7:0]      cmdByte,
  output logic                 cmdReady,
  // host result bytes
  output logic                 resValid,
  output logic [7:0]           resData,
  input  wire logic            resTake,
  // main status view
  output logic [3:0]           driveBusy,
  output logic                 cmdBusy,
  // settings owned elsewhere
  input  wire fdm_dumpCfg_type dumpCfg,
  // media identifier fields
  input  wire logic            idValid,
  input  wire logic            idCheckOk,
  input  wire fdm_idField_type idField,
  input  wire logic            idMissing,
  // implied seek engine
  output logic                 seekReq,
  output logic [7:0]           seekCyl,
  output logic [1:0]           seekDrive,
  input  wire logic            seekDone,
  input  wire logic            seekFail,
  input  wire logic [7:0]      seekErrSt0,
  input  wire logic [7:0]      seekFailCyl,
  // hand-off to transfer and other handlers
  output logic                 xferGo,
  output logic                 formatGo,
  output logic                 otherGo,
  output logic [7:0]           opcode,
  // perpendicular and lock state
  output logic [7:0]           perpMode,
  output logic                 lockOn
);
  // ===================================================================
  // opcode decode
  function automatic fdm_kind_type classify(input logic [7:0] b);
    logic [4:0] lo;
    lo = b[4:0];
    if (b == `FDM_OP_DUMP) classify = FDM_K_DUMP;
    else if ((b & `FDM_MASK_READID) == `FDM_OP_READID) classify = FDM_K_READID;
    else if (b == `FDM_OP_PERP) classify = FDM_K_PERP;
    else if ((b & `FDM_MASK_LOCK) == `FDM_OP_LOCK) classify = FDM_K_LOCK;
    else if ((b & `FDM_MASK_FORMAT) == `FDM_OP_FORMAT) classify = FDM_K_FORMAT;
    // transfers differ only in bits 0-4; upper bits are options
    else if (lo == 5'h06 || lo == 5'h0C || lo == 5'h05 || lo == 5'h09 ||
             lo == 5'h16 || lo == 5'h02) classify = FDM_K_XFER;
    else if (b == 8'h03 || b == 8'h04 || b == 8'h07 || b == 8'h08 ||
             b == 8'h0F || b == 8'h13 || (b & 8'hBF) == 8'h8F ||
             b == 8'h10) classify = FDM_K_OTHER;
    else classify = FDM_K_BAD;
  endfunction : classify

  fdm_state_type   state;
  fdm_kind_type    kind;
  logic [3:0]      parCnt;
  logic [3:0]      parNeed;
  logic [7:0]      selByte;
  logic [7:0]      reqCyl;
  logic [7:0]      reqSector;
  logic [7:0]      reqSize;
  logic [7:0]      scEot;
  logic [7:0]      resBuf [0:9];
  logic [3:0]      resLeft;
  logic            cmdFire;
  logic            lastPar;
  logic            seekFin;
  logic            idFin;
  fdm_kind_type    newKind;

  assign cmdReady = (state == FDM_S_IDLE) || (state == FDM_S_PARAM);
  assign cmdFire  = cmdValid && cmdReady;
  assign newKind  = classify(cmdByte);
  assign lastPar  = cmdFire && (state == FDM_S_PARAM) && (parCnt == parNeed);
  assign seekFin  = (state == FDM_S_SEEK) && seekDone;
  assign idFin    = (state == FDM_S_IDWAIT) && ((idValid && idCheckOk) || idMissing);
  assign resValid = (state == FDM_S_RESULT);
  assign resData  = resBuf[0];
  assign cmdBusy  = (state != FDM_S_IDLE);
  assign seekReq  = (state == FDM_S_SEEK);
  assign seekCyl  = reqCyl;
  // drive select leaves on seekDrive for the implied seek engine, on driveBusy and in read id result byte 0; no select pin is driven from here
  assign seekDrive = selByte[1:0];

  // ===================================================================
  // busy bit of the addressed drive while the implied seek runs
  always_comb
  begin
    driveBusy = 4'h0;
    if (state == FDM_S_SEEK)
      driveBusy[selByte[1:0]] = 1'b1;
  end

  // ===================================================================
  // command sequencing
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state   <= FDM_S_IDLE;
      kind    <= FDM_K_BAD;
      parCnt  <= 4'h0;
      parNeed <= 4'h0;
      opcode  <= 8'h00;
    end
    else
    begin
      case (state)
        FDM_S_IDLE:
          if (cmdFire)
          begin
            kind   <= newKind;
            opcode <= cmdByte;
            parCnt <= 4'h1;
            case (newKind)
              FDM_K_READID: parNeed <= `FDM_NPAR_READID;
              FDM_K_PERP:   parNeed <= `FDM_NPAR_PERP;
              FDM_K_XFER:   parNeed <= `FDM_NPAR_XFER;
              FDM_K_FORMAT: parNeed <= `FDM_NPAR_FORMAT;
              default:      parNeed <= 4'h0;
            endcase
            case (newKind)
              FDM_K_READID, FDM_K_PERP, FDM_K_XFER, FDM_K_FORMAT:
                state <= FDM_S_PARAM;
              // dump, lock and invalid answer at once with no parameters
              FDM_K_DUMP, FDM_K_LOCK, FDM_K_BAD: state <= FDM_S_RESULT;
              default: state <= FDM_S_IDLE;
            endcase
          end
        FDM_S_PARAM:
          if (cmdFire)
          begin
            parCnt <= parCnt + 4'h1;
            if (lastPar)
            begin
              case (kind)
                FDM_K_READID: state <= FDM_S_IDWAIT;
                FDM_K_XFER:
                  state <= dumpCfg.impliedSeekEnable ? FDM_S_SEEK : FDM_S_IDLE;
                default: state <= FDM_S_IDLE;
              endcase
            end
          end
        FDM_S_IDWAIT:
          if (idFin)
            state <= FDM_S_RESULT;
        FDM_S_SEEK:
          if (seekDone)
            state <= seekFail ? FDM_S_RESULT : FDM_S_IDLE;
        FDM_S_RESULT:
          if (resTake && resLeft == 4'h1)
            state <= FDM_S_IDLE;
        default: state <= FDM_S_IDLE;
      endcase
    end
  end

  // ===================================================================
  // parameter capture; the format/transfer choice steers the dump byte
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      selByte   <= 8'h00;
      reqCyl    <= 8'h00;
      reqSector <= 8'h00;
      reqSize   <= 8'h00;
      scEot     <= 8'h00;
    end
    else if (cmdFire && state == FDM_S_PARAM)
    begin
      if (parCnt == 4'h1)
        selByte <= cmdByte;
      if (kind == FDM_K_XFER)
      begin
        if (parCnt == `FDM_POS_CYL)
          reqCyl <= cmdByte;
        if (parCnt == `FDM_POS_SECTOR)
          reqSector <= cmdByte;
        if (parCnt == `FDM_POS_SIZE)
          reqSize <= cmdByte;
        if (parCnt == `FDM_POS_EOT)
          scEot <= cmdByte;
      end
      if (kind == FDM_K_FORMAT && parCnt == `FDM_POS_SC)
        scEot <= cmdByte;
    end
  end

  // ===================================================================
  // perpendicular and lock state
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      perpMode <= 8'h00;
      lockOn   <= 1'b0;
    end
    else
    begin
      if (lastPar && kind == FDM_K_PERP)
      begin
        // drive flags change only when overwrite is set
        if (cmdByte[`FDM_OW_BIT])
          perpMode[5:2] <= cmdByte[5:2];
        perpMode[1:0] <= cmdByte[1:0];
      end
      if (cmdFire && state == FDM_S_IDLE && newKind == FDM_K_LOCK)
        lockOn <= cmdByte[7];
    end
  end

  // ===================================================================
  // one-cycle hand-off pulses
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xferGo   <= 1'b0;
      formatGo <= 1'b0;
      otherGo  <= 1'b0;
    end
    else
    begin
      xferGo   <= (lastPar && kind == FDM_K_XFER && !dumpCfg.impliedSeekEnable) ||
                  (seekFin && !seekFail);
      formatGo <= lastPar && kind == FDM_K_FORMAT;
      otherGo  <= cmdFire && state == FDM_S_IDLE && newKind == FDM_K_OTHER;
    end
  end

  // ===================================================================
  // result buffer: loaded in one cycle, then shifted so resData is always a flop
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resLeft <= 4'h0;
      for (int i = 0; i < 10; i++)
        resBuf[i] <= 8'h00;
    end
    else if (cmdFire && state == FDM_S_IDLE && newKind == FDM_K_DUMP)
    begin
      resLeft   <= `FDM_RLEN_DUMP;
      resBuf[0] <= dumpCfg.cylDrive0;
      resBuf[1] <= dumpCfg.cylDrive1;
      resBuf[2] <= dumpCfg.cylDrive2;
      resBuf[3] <= dumpCfg.cylDrive3;
      resBuf[4] <= {dumpCfg.stepRateTime, dumpCfg.headUnloadTime};
      resBuf[5] <= {dumpCfg.headLoadTime, dumpCfg.nonDmaSelect};
      resBuf[6] <= scEot;
      resBuf[7] <= {lockOn, 1'b0, perpMode[5:0]};
      resBuf[8] <= {1'b0, dumpCfg.impliedSeekEnable, dumpCfg.fifoDisableBit,
                    dumpCfg.pollDisable, dumpCfg.fifoThreshold};
      resBuf[9] <= dumpCfg.precompStartTrack;
    end
    else if (cmdFire && state == FDM_S_IDLE && newKind == FDM_K_LOCK)
    begin
      resLeft   <= `FDM_RLEN_ONE;
      resBuf[0] <= 8'(cmdByte[7]) << `FDM_LOCK_BIT;
    end
    else if (cmdFire && state == FDM_S_IDLE && newKind == FDM_K_BAD)
    begin
      resLeft   <= `FDM_RLEN_ONE;
      resBuf[0] <= `FDM_ST0_INVALID;
    end
    else if (idFin)
    begin
      resLeft   <= `FDM_RLEN_SEVEN;
      resBuf[0] <= idMissing ? (`FDM_ST0_ABNORMAL | {5'h00, selByte[2:0]})
                             : {5'h00, selByte[2:0]};
      resBuf[1] <= idMissing ? `FDM_ST1_MISSING : 8'h00;
      resBuf[2] <= 8'h00;
      resBuf[3] <= idMissing ? 8'h00 : idField.cyl;
      resBuf[4] <= idMissing ? 8'h00 : idField.head;
      resBuf[5] <= idMissing ? 8'h00 : idField.sector;
      resBuf[6] <= idMissing ? 8'h00 : idField.size;
    end
    else if (seekFin && seekFail)
    begin
      resLeft   <= `FDM_RLEN_SEVEN;
      resBuf[0] <= seekErrSt0;
      resBuf[1] <= 8'h00;
      resBuf[2] <= 8'h00;
      resBuf[3] <= seekFailCyl;
      resBuf[4] <= {7'h00, selByte[2]};
      resBuf[5] <= reqSector;
      resBuf[6] <= reqSize;
    end
    else if (resValid && resTake)
    begin
      resLeft <= resLeft - 4'h1;
      for (int i = 0; i < 9; i++)
        resBuf[i] <= resBuf[i + 1];
      resBuf[9] <= 8'h00;
    end
  end

  // ===================================================================
  // checks
  invalid_result_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cmdFire && state == FDM_S_IDLE && newKind == FDM_K_BAD) |=>
      resValid && resData == `FDM_ST0_INVALID && resLeft == `FDM_RLEN_ONE)
    else $error("invalid opcode result wrong");
  // the last pop of any result must drop resValid on the next edge
  result_end_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (resValid && resTake && resLeft == 4'h1) |=> !resValid && cmdReady)
    else $error("result phase did not end");
  lock_echo_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cmdFire && state == FDM_S_IDLE && newKind == FDM_K_LOCK) |=>
      resData == {3'b000, $past(cmdByte[7]), 4'h0} && lockOn == $past(cmdByte[7]))
    else $error("lock echo wrong");
  dump_length_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cmdFire && state == FDM_S_IDLE && newKind == FDM_K_DUMP) |=>
      resValid && resLeft == 4'hA && resData == $past(dumpCfg.cylDrive0))
    else $error("dump start wrong");
  id_capture_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == FDM_S_IDWAIT && idValid && idCheckOk && !idMissing) |=>
      resValid && resBuf[3] == $past(idField.cyl) && resBuf[6] == $past(idField.size))
    else $error("read id capture wrong");
  id_seven_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    idFin |=> resLeft == 4'h7)
    else $error("read id length wrong");
  seek_busy_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == FDM_S_SEEK) |-> driveBusy == (4'h1 << selByte[1:0]) && cmdBusy)
    else $error("drive busy wrong in seek");
  seek_entry_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (lastPar && kind == FDM_K_XFER && dumpCfg.impliedSeekEnable) |=>
      seekReq && seekCyl == reqCyl && !xferGo)
    else $error("implied seek not started");
  seek_fail_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (seekFin && seekFail) |=>
      resValid && resData == $past(seekErrSt0) && resBuf[3] == $past(seekFailCyl))
    else $error("seek failure result wrong");
  dump_count_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cmdFire && state == FDM_S_PARAM && kind == FDM_K_FORMAT && parCnt == `FDM_POS_SC) |=>
      scEot == $past(cmdByte))
    else $error("format count not captured");
  eot_track_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cmdFire && state == FDM_S_PARAM && kind == FDM_K_XFER && parCnt == 4'h6) |=>
      scEot == $past(cmdByte))
    else $error("end of track not captured");
  perp_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (lastPar && kind == FDM_K_PERP && !cmdByte[7]) |=>
      perpMode[5:2] == $past(perpMode[5:2]) && perpMode[1:0] == $past(cmdByte[1:0]))
    else $error("perpendicular flags changed without overwrite");
  dump_seen_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    cmdFire && state == FDM_S_IDLE && newKind == FDM_K_DUMP);
  id_done_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    idFin && !idMissing);
  seek_fail_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    seekFin && seekFail);
  invalid_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    cmdFire && state == FDM_S_IDLE && newKind == FDM_K_BAD);
endmodule : fdm_misc_cmd
`default_nettype wire

// File: fdm_params.svh
// constants for the floppy misc command handler: opcodes, counts, field positions
// assumes inclusion by fdm_misc_cmd.sv and the bench
`ifndef FDM_PARAMS_SVH
`define FDM_PARAMS_SVH
// =====================================================================
// opcodes (read id, lock and format compared after masking)
`define FDM_OP_DUMP      8'h0E
`define FDM_OP_READID    8'h0A
`define FDM_MASK_READID  8'hBF
`define FDM_OP_PERP      8'h12
`define FDM_OP_LOCK      8'h14
`define FDM_MASK_LOCK    8'h7F
`define FDM_OP_FORMAT    8'h0D
`define FDM_MASK_FORMAT  8'hBF
`define FDM_MASK_XFER    8'h1F
// =====================================================================
// parameter byte counts after the opcode
`define FDM_NPAR_READID  4'h1
`define FDM_NPAR_PERP    4'h1
`define FDM_NPAR_XFER    4'h8
`define FDM_NPAR_FORMAT  4'h5
// parameter byte positions (1 = first byte after opcode)
`define FDM_POS_CYL      4'h2
`define FDM_POS_SECTOR   4'h4
`define FDM_POS_SIZE     4'h5
`define FDM_POS_EOT      4'h6
`define FDM_POS_SC       4'h3
// =====================================================================
// result lengths and fixed values
`define FDM_RLEN_DUMP    4'hA
`define FDM_RLEN_SEVEN   4'h7
`define FDM_RLEN_ONE     4'h1
`define FDM_ST0_INVALID  8'h80
`define FDM_ST0_ABNORMAL 8'h40
`define FDM_ST1_MISSING  8'h01
`define FDM_LOCK_BIT     4
`define FDM_OW_BIT       7
`endif

// File: fdm_pkg.sv
// types for the floppy misc command handler
// assumes fdm_params.svh holds the numeric constants
`default_nettype none
package fdm_pkg;
  // identifier field as read from the media
  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } fdm_idField_type;
  // settings owned by other command handlers, shown in the register dump
  typedef struct packed {
    logic [7:0] cylDrive0;
    logic [7:0] cylDrive1;
    logic [7:0] cylDrive2;
    logic [7:0] cylDrive3;
    logic [3:0] stepRateTime;
    logic [3:0] headUnloadTime;
    logic [6:0] headLoadTime;
    logic       nonDmaSelect;
    logic       impliedSeekEnable;
    logic       fifoDisableBit;
    logic       pollDisable;
    logic [3:0] fifoThreshold;
    logic [7:0] precompStartTrack;
  } fdm_dumpCfg_type;
  typedef enum logic [2:0] {
    FDM_K_DUMP   = 3'b000,
    FDM_K_READID = 3'b001,
    FDM_K_PERP   = 3'b010,
    FDM_K_LOCK   = 3'b011,
    FDM_K_XFER   = 3'b100,
    FDM_K_FORMAT = 3'b101,
    FDM_K_OTHER  = 3'b110,
    FDM_K_BAD    = 3'b111
  } fdm_kind_type;
  typedef enum logic [2:0] {
    FDM_S_IDLE   = 3'b000,
    FDM_S_PARAM  = 3'b001,
    FDM_S_IDWAIT = 3'b010,
    FDM_S_SEEK   = 3'b011,
    FDM_S_RESULT = 3'b100
  } fdm_state_type;
endpackage : fdm_pkg
`default_nettype wire

// File: fdm_media_model.sv
// media and implied seek engine model facing fdm_misc_cmd
// assumes the bench pulses idGo and sets idLost and failSeek
`timescale 1ns/1ps
`default_nettype none
module fdm_media_model
  import fdm_pkg::*;
#(
  parameter logic [7:0] ERR_ST0  = 8'h70,
  parameter logic [7:0] FAIL_CYL = 8'h27
)
(
  // clock
  input  wire logic            sys_clk,
  // bench controls
  input  wire logic            idGo,
  input  wire logic            idLost,
  input  wire logic            failSeek,
  input  wire fdm_idField_type goodId,
  // identifier fields
  output logic                 idValid,
  output logic                 idCheckOk,
  output fdm_idField_type      idField,
  output logic                 idMissing,
  // seek engine
  input  wire logic            seekReq,
  output logic                 seekDone,
  output logic                 seekFail,
  output logic [7:0]           seekErrSt0,
  output logic [7:0]           seekFailCyl
);
  int k;
  // id stream: a bad field, a good one, then a later good one
  initial
  begin
    {idValid, idCheckOk, idMissing} = 3'h0;
    idField = '1;
    forever
    begin
      @(posedge idGo);
      @(posedge sys_clk);
      #1;
      idMissing = idLost;
      idValid = ~idLost;
      idField = ~goodId;
      @(posedge sys_clk);
      #1;
      idMissing = 1'b0;
      idCheckOk = 1'b1;
      idField = goodId;
      @(posedge sys_clk);
      #1;
      idField = fdm_idField_type'(goodId + 32'h01010101);
      @(posedge sys_clk);
      #1;
      {idValid, idCheckOk} = 2'h0;
      idField = ~idField;
    end
  end
  // seek answers after four cycles; stale fields toggle so no reuse goes unseen
  // one process owns every seek output, so the toggling starts from known values
  initial
  begin
    k = 0;
    {seekDone, seekFail} = 2'h0;
    {seekErrSt0, seekFailCyl} = 16'h0000;
    forever
    begin
      @(posedge sys_clk);
      #1;
      if (seekReq === 1'b1 && k == 3)
      begin
        k = 0;
        seekDone = 1'b1;
        seekFail = failSeek;
        seekErrSt0 = ERR_ST0;
        seekFailCyl = FAIL_CYL;
      end
      else
      begin
        k = (seekReq === 1'b1) ? k + 1 : 0;
        seekDone = 1'b0;
        seekFail = ~seekFail;
        seekErrSt0 = ~seekErrSt0;
        seekFailCyl = ~seekFailCyl;
      end
    end
  end
endmodule : fdm_media_model
`default_nettype wire

// File: testbench.sv
// self-checking bench for fdm_misc_cmd
// assumes fdm_media_model stands for the drive side
`timescale 1ns/1ps
`default_nettype none
`include "fdm_params.svh"
module testbench
  import fdm_pkg::*;
;
  logic            sys_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic            cmdValid, cmdReady, resValid, resTake, cmdBusy;
  logic [7:0]      cmdByte, resData, seekCyl, opcode, perpMode;
  logic [7:0]      seekErrSt0, seekFailCyl;
  logic [3:0]      driveBusy;
  logic [1:0]      seekDrive;
  logic            idValid, idCheckOk, idMissing, seekReq, seekDone, seekFail;
  logic            xferGo, formatGo, otherGo, lockOn, idGo, idLost, failSeek;
  fdm_dumpCfg_type dumpCfg;
  fdm_idField_type idField, goodId;
  int              errors = 0;
  int              n_tests = 0;
  int              nXfer = 0;
  int              nFmt = 0;
  int              nOther = 0;
  logic [7:0]      expPerp = 8'h00;
  logic            expLock = 1'b0;

  fdm_misc_cmd dut_u (.*);
  fdm_media_model #(.ERR_ST0(8'h70), .FAIL_CYL(8'h27)) model_u (.*);

  always #2.5 sys_clk = ~sys_clk;
  // count hand-off pulses, each stands one cycle
  always @(posedge sys_clk)
  begin
    nXfer <= nXfer + int'(xferGo === 1'b1);
    nFmt <= nFmt + int'(formatGo === 1'b1);
    nOther <= nOther + int'(otherGo === 1'b1);
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one byte, held until an edge with cmdReady high takes it
  task automatic send(input logic [7:0] b);
    cmdByte = b;
    cmdValid = 1'b1;
    for (int i = 0; i < 200 && cmdReady !== 1'b1; i++) tick();
    tick();
  endtask : send
  task automatic cmd(input logic [7:0] q[$]);
    foreach (q[i]) send(q[i]);
    cmdValid = 1'b0;
    tick();
  endtask : cmd
  // pop one result byte; a gap cycle keeps resTake a clean pulse
  task automatic res(input string nm, input logic [7:0] exp);
    for (int i = 0; i < 200 && resValid !== 1'b1; i++) tick();
    chk(nm, exp, resData);
    chk("cmdReady in result", 8'h00, {7'h00, cmdReady});
    resTake = 1'b1;
    tick();
    resTake = 1'b0;
    tick();
  endtask : res
  task automatic res_all(input logic [7:0] e[$]);
    foreach (e[i]) res($sformatf("result byte %0d", i), e[i]);
    chk("resValid after last", 8'h00, {7'h00, resValid});
  endtask : res_all
  task automatic dump_check(input logic [7:0] cnt);
    cmd('{`FDM_OP_DUMP});
    res_all('{dumpCfg.cylDrive0, dumpCfg.cylDrive1, dumpCfg.cylDrive2, dumpCfg.cylDrive3,
      {dumpCfg.stepRateTime, dumpCfg.headUnloadTime}, {dumpCfg.headLoadTime, dumpCfg.nonDmaSelect},
      cnt, {expLock, 1'b0, expPerp[5:0]}, {1'b0, dumpCfg.impliedSeekEnable,
      dumpCfg.fifoDisableBit, dumpCfg.pollDisable, dumpCfg.fifoThreshold},
      dumpCfg.precompStartTrack});
  endtask : dump_check

  // lock off then on, echoed in bit four
  task automatic t_lock();
    for (int lk = 0; lk < 2; lk++)
    begin
      cmd('{{lk[0], 7'h14}});
      res_all('{{3'h0, lk[0], 4'h0}});
      chk("lockOn", {7'h00, lk[0]}, {7'h00, lockOn});
    end
    expLock = 1'b1;
  endtask : t_lock
  // drive flags move only with overwrite set
  task automatic t_perp();
    cmd('{8'h12, 8'hBE});
    chk("perpMode ow", 8'h3E, perpMode);
    cmd('{8'h12, 8'h01});
    chk("perpMode keep", 8'h3D, perpMode);
    expPerp = 8'h3D;
  endtask : t_perp
  task automatic t_format_dump();
    cmd('{8'h4D, 8'h00, 8'h02, 8'h12, 8'h1B, 8'hE5});
    chk("formatGo", 8'h01, 8'(nFmt));
    dump_check(8'h12);
  endtask : t_format_dump
  // each transfer code except 02 takes nine bytes and hands off alike
  task automatic t_xfer_codes();
    logic [7:0] codes[7] = '{8'h06, 8'h05, 8'h0C, 8'h09, 8'h16, 8'h46, 8'hC5};
    foreach (codes[i])
    begin
      cmd('{codes[i], 8'h00, 8'h03, 8'h00, 8'h01, 8'h02, 8'h10 + 8'(i), 8'h1B, 8'hFF});
      chk("xferGo count", 8'(i + 1), 8'(nXfer));
      chk("opcode", codes[i], opcode);
    end
    dump_check(8'h16);
  endtask : t_xfer_codes
  task automatic t_invalid_other();
    cmd('{8'h00});
    res_all('{`FDM_ST0_INVALID});
    cmd('{8'h08});
    chk("otherGo", 8'h01, 8'(nOther));
  endtask : t_invalid_other
  // read id keeps the first good field, then the give-up case
  task automatic t_read_id();
    goodId = '{8'h05, 8'h01, 8'h07, 8'h02};
    cmd('{8'h4A, 8'h06});
    idGo = 1'b1;
    tick();
    idGo = 1'b0;
    res_all('{8'h06, 8'h00, 8'h00, 8'h05, 8'h01, 8'h07, 8'h02});
    idLost = 1'b1;
    cmd('{8'h0A, 8'h01});
    idGo = 1'b1;
    tick();
    idGo = 1'b0;
    res_all('{8'h41, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    idLost = 1'b0;
  endtask : t_read_id
  // implied seek: success on drive 1, failure on drive 2
  task automatic t_seek();
    int n0;
    dumpCfg.impliedSeekEnable = 1'b1;
    for (int f = 0; f < 2; f++)
    begin
      n0 = nXfer;
      failSeek = f[0];
      // same drive as seekDrive shows
      cmd('{8'hC6, {6'h01, 2'(f + 1)}, 8'h2A, 8'h01, 8'h03, 8'h02, 8'h09, 8'h1B, 8'hFF});
      for (int i = 0; i < 50 && seekReq !== 1'b1; i++) tick();
      chk("seekCyl", 8'h2A, seekCyl);
      chk("seekDrive", 8'(f + 1), {6'h00, seekDrive});
      chk("driveBusy", 8'(2 << f), {4'h0, driveBusy});
      chk("cmdReady in seek", 8'h00, {7'h00, cmdReady});
      chk("cmdBusy in seek", 8'h01, {7'h00, cmdBusy});
      if (f == 0)
      begin
        for (int i = 0; i < 50 && nXfer == n0; i++) tick();
        chk("xferGo after seek", 8'(n0 + 1), 8'(nXfer));
        chk("driveBusy after", 8'h00, {4'h0, driveBusy});
      end
      else
        res_all('{8'h70, 8'h00, 8'h00, 8'h27, 8'h01, 8'h03, 8'h02});
    end
    dumpCfg.impliedSeekEnable = 1'b0;
  endtask : t_seek

  task automatic final_report();
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // main sequence
  initial
  begin
    {cmdValid, resTake, idGo, idLost, failSeek} = 5'h00;
    cmdByte = 8'h00;
    goodId = '0;
    dumpCfg = '{8'h11, 8'h22, 8'h33, 8'h44, 4'h5, 4'hA, 7'h35, 1'b1, 1'b0, 1'b1, 1'b0,
      4'h7, 8'h66};
    repeat (3) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    t_lock();
    t_perp();
    t_format_dump();
    t_xfer_codes();
    t_invalid_other();
    t_read_id();
    t_seek();
    final_report();
  end
  // watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
